// file: hw/gxp_pkg.sv
package gxp_pkg;

  localparam int PORT_W    = 8;
  localparam int SYNC_W    = 21;
  localparam int SCL_POS   = 20;
  localparam int SDA_POS   = 19;
  localparam int STRAP_MSB = 18;
  localparam int STRAP_LSB = 16;
  localparam int PINS_MSB  = 15;

  localparam logic [3:0] ADDR_FIXED = 4'h4;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] CNT_ONE    = 4'h1;
  localparam logic [3:0] CNT_ZERO   = 4'h0;

  // command groups, low bit picks the port
  localparam logic [1:0] GRP_IN  = 2'h0;
  localparam logic [1:0] GRP_OUT = 2'h1;
  localparam logic [1:0] GRP_POL = 2'h2;
  localparam logic [1:0] GRP_CFG = 2'h3;

  localparam logic [2:0] PTR_RST = 3'h0;
  localparam logic [7:0] OUT_RST = 8'hff;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'hff;

  typedef enum logic [2:0] {
    GXP_IDLE = 3'h0,
    GXP_ADDR = 3'h1,
    GXP_ACK  = 3'h3,
    GXP_RX   = 3'h2,
    GXP_TX   = 3'h6,
    GXP_MACK = 3'h7
  } gxp_state_e;

endpackage : gxp_pkg

// file: hw/gxp_port_irq.sv
`timescale 1ns/1ps
module gxp_port_irq #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pins,
  input  wire logic [WIDTH-1:0] isInput,
  input  wire logic             clear,
  output logic                  pending
);

  logic [WIDTH-1:0] snap_q;
  logic             seeded_q;
  logic [WIDTH-1:0] changed;

  // only input-mode pins that differ from the snapshot count
  assign changed = (pins ^ snap_q) & isInput;

  // snapshot taken after reset release, not under reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snap_q   <= '0;
      seeded_q <= 1'b0;
      pending  <= 1'b0;
    end else begin
      seeded_q <= 1'b1;
      if (!seeded_q || clear) begin
        snap_q <= pins;
      end
      pending <= seeded_q && !clear && (|changed);
    end
  end

endmodule : gxp_port_irq

// file: hw/gxp_sync.sv
`timescale 1ns/1ps
module gxp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  // two stages; the first is read only by the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '1;
      dout   <= '1;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule : gxp_sync

// file: hw/gxp_target.sv
`timescale 1ns/1ps
module gxp_target (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           sclIn,
  input  wire logic                           sdaIn,
  output logic                                sdaOut,
  output logic                                sdaOe,
  input  wire logic                           addrStrapBit0,
  input  wire logic                           addrStrapBit1,
  input  wire logic                           addrStrapBit2,
  input  wire logic [gxp_pkg::PORT_W-1:0]     firstPortPinsIn,
  output logic      [gxp_pkg::PORT_W-1:0]     firstPortPinsOut,
  output logic      [gxp_pkg::PORT_W-1:0]     firstPortPinsOe,
  input  wire logic [gxp_pkg::PORT_W-1:0]     secondPortPinsIn,
  output logic      [gxp_pkg::PORT_W-1:0]     secondPortPinsOut,
  output logic      [gxp_pkg::PORT_W-1:0]     secondPortPinsOe,
  output logic                                alertOut,
  output logic                                alertOe
);
  import gxp_pkg::*;

  // synchronised pins
  logic [SYNC_W-1:0]      syncRaw;
  logic [SYNC_W-1:0]      syncOut;
  logic                   sclS;
  logic                   sdaS;
  logic [2:0]             strapS;
  logic [1:0][PORT_W-1:0] pinS;

  // bus edge detection
  logic                   sclPrev_q;
  logic                   sdaPrev_q;
  logic                   sclRise;
  logic                   sclFall;
  logic                   startCond;
  logic                   stopCond;

  // protocol machine
  gxp_state_e             state_q;
  gxp_state_e             state_d;
  logic [3:0]             bitCnt_q;
  logic [3:0]             bitCnt_d;
  logic [7:0]             shift_q;
  logic [7:0]             shift_d;
  logic [7:0]             tx_q;
  logic [7:0]             tx_d;
  logic                   sdaOe_q;
  logic                   sdaOe_d;
  logic                   rw_q;
  logic                   rw_d;
  logic                   cmdNext_q;
  logic                   cmdNext_d;
  logic                   afterAddr_q;
  logic                   afterAddr_d;
  logic                   hostAck_q;
  logic                   hostAck_d;
  logic                   addrHit;
  logic                   byteDone;

  // strobes from the machine
  logic                   wrStrobe;
  logic                   cmdStrobe;
  logic                   fetch;
  logic                   fetchNext;

  // register file
  logic [2:0]             ptr_q;
  logic [2:0]             ptrAlt;
  logic [2:0]             fetchSel;
  logic [1:0]             ptrGrp;
  logic [1:0]             selGrp;
  logic                   selPort;
  logic [7:0]             rdByte;
  logic [1:0][PORT_W-1:0] outQ;
  logic [1:0][PORT_W-1:0] polQ;
  logic [1:0][PORT_W-1:0] cfgQ;
  logic [1:0][PORT_W-1:0] pinOe_q;
  logic                   wrOut;
  logic                   wrPol;
  logic                   wrCfg;

  // alert path
  logic [1:0]             clrPort;
  logic [1:0]             pend;
  logic                   alertOe_q;
  logic                   zero_q;

  // every pin, straps included, crosses in through two stages
  assign syncRaw = {sclIn, sdaIn, addrStrapBit2, addrStrapBit1, addrStrapBit0,
                    secondPortPinsIn, firstPortPinsIn};

  gxp_sync #(
    .WIDTH (SYNC_W)
  ) uSync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (syncRaw),
    .dout  (syncOut)
  );

  assign sclS   = syncOut[SCL_POS];
  assign sdaS   = syncOut[SDA_POS];
  assign strapS = syncOut[STRAP_MSB:STRAP_LSB];
  assign pinS   = syncOut[PINS_MSB:0];

  // conditions on the sampled lines
  assign sclRise   = sclS & ~sclPrev_q;
  assign sclFall   = ~sclS & sclPrev_q;
  assign startCond = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  assign stopCond  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

  // address match and byte boundary
  assign addrHit  = (shift_q[7:1] == {ADDR_FIXED, strapS});
  assign byteDone = sclFall && (bitCnt_q == BYTE_BITS);

  // register selection; the pair partner differs in the low bit
  assign ptrAlt   = {ptr_q[2:1], ~ptr_q[0]};
  assign fetchSel = (state_q == GXP_MACK) ? ptrAlt : ptr_q;
  assign ptrGrp   = ptr_q[2:1];
  assign selGrp   = fetchSel[2:1];
  assign selPort  = fetchSel[0];

  // read mux; outputs read back from the flops, not the pins
  assign rdByte = (selGrp == GRP_IN)  ? (pinS[selPort] ^ polQ[selPort]) :
                  (selGrp == GRP_OUT) ? outQ[selPort] :
                  (selGrp == GRP_POL) ? polQ[selPort] :
                                        cfgQ[selPort];

  // write decode; input registers ignore writes
  assign wrOut = wrStrobe && (ptrGrp == GRP_OUT);
  assign wrPol = wrStrobe && (ptrGrp == GRP_POL);
  assign wrCfg = wrStrobe && (ptrGrp == GRP_CFG);

  // a fetch of an input register clears only that port
  assign clrPort[0] = (fetch | fetchNext) && (selGrp == GRP_IN) && !selPort;
  assign clrPort[1] = (fetch | fetchNext) && (selGrp == GRP_IN) && selPort;

  // protocol machine; a start or stop anywhere overrides the state
  always_comb begin
    state_d     = state_q;
    bitCnt_d    = bitCnt_q;
    shift_d     = shift_q;
    tx_d        = tx_q;
    sdaOe_d     = sdaOe_q;
    rw_d        = rw_q;
    cmdNext_d   = cmdNext_q;
    afterAddr_d = afterAddr_q;
    hostAck_d   = hostAck_q;
    wrStrobe    = 1'b0;
    cmdStrobe   = 1'b0;
    fetch       = 1'b0;
    fetchNext   = 1'b0;
    if (stopCond) begin
      state_d = GXP_IDLE;
      sdaOe_d = 1'b0;
    end else if (startCond) begin
      state_d  = GXP_ADDR;
      bitCnt_d = CNT_ZERO;
      sdaOe_d  = 1'b0;
    end else begin
      case (state_q)
        GXP_IDLE: begin
          sdaOe_d = 1'b0;
        end
        GXP_ADDR, GXP_RX: begin
          if (sclRise) begin
            shift_d  = {shift_q[6:0], sdaS};
            bitCnt_d = bitCnt_q + CNT_ONE;
          end else if (byteDone) begin
            afterAddr_d = (state_q == GXP_ADDR);
            if (state_q == GXP_RX) begin
              state_d = GXP_ACK;
              sdaOe_d = 1'b1;
            end else if (addrHit) begin
              rw_d      = shift_q[0];
              cmdNext_d = ~shift_q[0];
              state_d   = GXP_ACK;
              sdaOe_d   = 1'b1;
            end else begin
              state_d = GXP_IDLE;
            end
          end
        end
        GXP_ACK: begin
          if (sclRise) begin
            if (afterAddr_q) begin
              fetch = rw_q;
            end else if (cmdNext_q) begin
              cmdStrobe = 1'b1;
              cmdNext_d = 1'b0;
            end else begin
              wrStrobe = 1'b1;
            end
            if (afterAddr_q && rw_q) begin
              tx_d = rdByte;
            end
          end else if (sclFall) begin
            if (rw_q) begin
              state_d  = GXP_TX;
              sdaOe_d  = ~tx_q[7];
              tx_d     = {tx_q[6:0], 1'b0};
              bitCnt_d = CNT_ONE;
            end else begin
              state_d  = GXP_RX;
              sdaOe_d  = 1'b0;
              bitCnt_d = CNT_ZERO;
            end
          end
        end
        GXP_TX: begin
          if (byteDone) begin
            state_d = GXP_MACK;
            sdaOe_d = 1'b0;
          end else if (sclFall) begin
            sdaOe_d  = ~tx_q[7];
            tx_d     = {tx_q[6:0], 1'b0};
            bitCnt_d = bitCnt_q + CNT_ONE;
          end
        end
        GXP_MACK: begin
          if (sclRise) begin
            hostAck_d = ~sdaS;
            fetchNext = ~sdaS;
            if (!sdaS) begin
              tx_d = rdByte;
            end
          end else if (sclFall) begin
            if (hostAck_q) begin
              state_d  = GXP_TX;
              sdaOe_d  = ~tx_q[7];
              tx_d     = {tx_q[6:0], 1'b0};
              bitCnt_d = CNT_ONE;
            end else begin
              state_d = GXP_IDLE;
            end
          end
        end
        default: begin
          state_d = GXP_IDLE;
          sdaOe_d = 1'b0;
        end
      endcase
    end
  end

  // machine state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q     <= GXP_IDLE;
      bitCnt_q    <= CNT_ZERO;
      shift_q     <= '0;
      tx_q        <= '0;
      sdaOe_q     <= 1'b0;
      rw_q        <= 1'b0;
      cmdNext_q   <= 1'b0;
      afterAddr_q <= 1'b0;
      hostAck_q   <= 1'b0;
      sclPrev_q   <= 1'b1;
      sdaPrev_q   <= 1'b1;
    end else begin
      state_q     <= state_d;
      bitCnt_q    <= bitCnt_d;
      shift_q     <= shift_d;
      tx_q        <= tx_d;
      sdaOe_q     <= sdaOe_d;
      rw_q        <= rw_d;
      cmdNext_q   <= cmdNext_d;
      afterAddr_q <= afterAddr_d;
      hostAck_q   <= hostAck_d;
      sclPrev_q   <= sclS;
      sdaPrev_q   <= sdaS;
    end
  end

  // command pointer follows the register in use, so a restart reads it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_q <= PTR_RST;
    end else if (cmdStrobe) begin
      ptr_q <= shift_q[2:0];
    end else if (wrStrobe || fetchNext) begin
      ptr_q <= ptrAlt;
    end
  end

  // writable registers hold the last acked byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outQ <= {OUT_RST, OUT_RST};
      polQ <= {POL_RST, POL_RST};
      cfgQ <= {CFG_RST, CFG_RST};
    end else begin
      if (wrOut) outQ[ptr_q[0]] <= shift_q;
      if (wrPol) polQ[ptr_q[0]] <= shift_q;
      if (wrCfg) cfgQ[ptr_q[0]] <= shift_q;
    end
  end

  // one change tracker per port
  gxp_port_irq #(
    .WIDTH   (PORT_W)
  ) uIrq0 (
    .clk     (clk),
    .rst_n   (rst_n),
    .pins    (pinS[0]),
    .isInput (cfgQ[0]),
    .clear   (clrPort[0]),
    .pending (pend[0])
  );

  gxp_port_irq #(
    .WIDTH   (PORT_W)
  ) uIrq1 (
    .clk     (clk),
    .rst_n   (rst_n),
    .pins    (pinS[1]),
    .isInput (cfgQ[1]),
    .clear   (clrPort[1]),
    .pending (pend[1])
  );

  // output flops; direction one releases the pin driver
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinOe_q   <= '0;
      alertOe_q <= 1'b0;
      zero_q    <= 1'b0;
    end else begin
      pinOe_q   <= ~cfgQ;
      alertOe_q <= |pend;
      zero_q    <= 1'b0;
    end
  end

  // open-drain lines only ever drive low
  assign sdaOut            = zero_q;
  assign sdaOe             = sdaOe_q;
  assign alertOut          = zero_q;
  assign alertOe           = alertOe_q;
  assign firstPortPinsOut  = outQ[0];
  assign secondPortPinsOut = outQ[1];
  assign firstPortPinsOe   = pinOe_q[0];
  assign secondPortPinsOe  = pinOe_q[1];

endmodule : gxp_target

// file: tb/gxp_bus_ctrl.sv
`timescale 1ns/1ps
module gxp_bus_ctrl #(
  parameter int HALF = 200
) (
  input  wire logic sdaLine,
  output logic      sclLine,
  output logic      sdaPullLow
);
  // idle bus: both lines released, pull-ups hold them high
  initial begin
    sclLine = 1'b1;
    sdaPullLow = 1'b0;
  end

  // start or repeated start, always from a released data line
  task automatic busStart();
    sdaPullLow = 1'b0;
    #(HALF);
    sclLine = 1'b1;
    #(HALF);
    sdaPullLow = 1'b1;
    #(HALF);
    sclLine = 1'b0;
  endtask : busStart

  // stop leaves the bus idle for the next start
  task automatic busStop();
    #(HALF/2);
    sdaPullLow = 1'b1;
    #(HALF/2);
    sclLine = 1'b1;
    #(HALF);
    sdaPullLow = 1'b0;
    #(HALF);
  endtask : busStop

  // data moves only mid low phase, sampled at the end of high
  task automatic busBit(input logic b, output logic r);
    #(HALF/2);
    sdaPullLow = !b;
    #(HALF/2);
    sclLine = 1'b1;
    #(HALF);
    r = sdaLine;
    sclLine = 1'b0;
  endtask : busBit

  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      busBit(b[i], r);
    end
    busBit(1'b1, r);
    ack = !r;
  endtask : sendByte

  // last byte left unacknowledged by the caller
  task automatic recvByte(input logic ackIt, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      busBit(1'b1, r);
      b[i] = r;
    end
    busBit(!ackIt, r);
  endtask : recvByte
endmodule : gxp_bus_ctrl

// file: tb/gxp_target_monitor.sv
`timescale 1ns/1ps
module gxp_target_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       sclIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic [7:0] firstPortPinsIn,
  input wire logic [7:0] firstPortPinsOut,
  input wire logic [7:0] firstPortPinsOe,
  input wire logic [7:0] secondPortPinsIn,
  input wire logic [7:0] secondPortPinsOut,
  input wire logic [7:0] secondPortPinsOe,
  input wire logic       alertOut,
  input wire logic       alertOe
);
  logic [3:0] quietCnt;
  default clocking monClk @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // cycles since a pin or direction moved; an alert edge needs a recent cause
  always_ff @(posedge clk) begin
    if (!rst_n || $changed(firstPortPinsIn) || $changed(secondPortPinsIn)
        || $changed(firstPortPinsOe) || $changed(secondPortPinsOe)) begin
      quietCnt <= 4'h0;
    end else if (quietCnt != 4'hf) begin
      quietCnt <= quietCnt + 4'h1;
    end
  end

  a_alert_pull_only: assert property (alertOe |-> !alertOut)
    else $error("alert line driven high");
  a_sda_pull_only: assert property (sdaOe |-> !sdaOut)
    else $error("data line driven high");
  a_reset_defaults: assert property (disable iff (1'b0) !rst_n |=> !alertOe && !sdaOe
    && firstPortPinsOe == 8'h00 && secondPortPinsOe == 8'h00
    && firstPortPinsOut == 8'hff && secondPortPinsOut == 8'hff)
    else $error("reset defaults wrong");
  a_sda_change_low: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data drive moved while clock high");
  a_load_in_ack: assert property ($changed(firstPortPinsOut) || $changed(secondPortPinsOut)
    || $changed(firstPortPinsOe) || $changed(secondPortPinsOe) |-> sclIn && sdaOe)
    else $error("register load outside ack pulse");
  a_alert_cause: assert property ($rose(alertOe) |-> quietCnt < 4'h8)
    else $error("alert without pin change");
  a_alert_drop: assert property ($fell(alertOe) |-> quietCnt < 4'h8 || sclIn)
    else $error("alert dropped without cause");
  a_drive_min: assert property ($rose(sdaOe) |-> sdaOe [*8])
    else $error("data drive too short");
  a_drive_bound: assert property ($rose(sdaOe) |-> ##[1:400] !sdaOe)
    else $error("data line never released");

  c_alert: cover property ($rose(alertOe));
  c_ack: cover property ($rose(sdaOe));
  c_load: cover property ($changed(firstPortPinsOut));
endmodule : gxp_target_monitor

bind gxp_target gxp_target_monitor mon_u (
  .clk(clk), .rst_n(rst_n), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .firstPortPinsIn(firstPortPinsIn), .firstPortPinsOut(firstPortPinsOut),
  .firstPortPinsOe(firstPortPinsOe), .secondPortPinsIn(secondPortPinsIn),
  .secondPortPinsOut(secondPortPinsOut), .secondPortPinsOe(secondPortPinsOe),
  .alertOut(alertOut), .alertOe(alertOe)
);

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import gxp_pkg::*;
  logic            clk;
  logic            rst_n;
  logic            sdaOe;
  logic            alertOe;
  logic            sclLine;
  logic            sdaPullLow;
  logic [2:0]      strap;
  logic [7:0]      drv0, drv1, out0, out1, oe0, oe1, b0, b1;
  int              mismatches;
  int              samples_checked;
  // wired bus and pin levels from every party
  wire logic       sdaLine = ~(sdaPullLow | sdaOe);
  wire logic [7:0] pins0 = (oe0 & out0) | (~oe0 & drv0);
  wire logic [7:0] pins1 = (oe1 & out1) | (~oe1 & drv1);

  gxp_target dut_u (
    .clk(clk), .rst_n(rst_n), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe),
    .addrStrapBit0(strap[0]), .addrStrapBit1(strap[1]), .addrStrapBit2(strap[2]),
    .firstPortPinsIn(pins0), .firstPortPinsOut(out0), .firstPortPinsOe(oe0),
    .secondPortPinsIn(pins1), .secondPortPinsOut(out1), .secondPortPinsOe(oe1),
    .alertOut(), .alertOe(alertOe)
  );
  gxp_bus_ctrl #(.HALF(200)) bus_u (
    .sdaLine(sdaLine), .sclLine(sclLine), .sdaPullLow(sdaPullLow)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // edges land before inputs move
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic sendChk(input logic [7:0] b, input logic expAck);
    logic a;
    bus_u.sendByte(b, a);
    check({7'h0, a}, {7'h0, expAck});
  endtask : sendChk

  task automatic wrReg(input logic [7:0] cmd, d0, d1);
    bus_u.busStart();
    sendChk(8'h4a, 1'b1);
    sendChk(cmd, 1'b1);
    sendChk(d0, 1'b1);
    sendChk(d1, 1'b1);
    bus_u.busStop();
  endtask : wrReg

  // command write, repeated start, one or two bytes back
  task automatic rdReg(input logic [7:0] cmd, input logic two, output logic [7:0] r0, r1);
    bus_u.busStart();
    sendChk(8'h4a, 1'b1);
    sendChk(cmd, 1'b1);
    bus_u.busStart();
    sendChk(8'h4b, 1'b1);
    bus_u.recvByte(two, r0);
    if (two) begin
      bus_u.recvByte(1'b0, r1);
    end
    bus_u.busStop();
  endtask : rdReg

  task automatic t_reset();
    check(oe0, 8'h00);
    check(oe1, 8'h00);
    check(out0, 8'hff);
    check(out1, 8'hff);
    check({7'h0, alertOe}, 8'h00);
    $display("reset test done");
  endtask : t_reset

  task automatic t_write();
    wrReg(8'h02, 8'h5a, 8'h3c);
    check(out0, 8'h5a);
    check(out1, 8'h3c);
    wrReg(8'h06, 8'h0f, 8'hff);
    tick(10);
    check(oe0, 8'hf0);
    check(oe1, 8'h00);
    check({7'h0, alertOe}, 8'h00);
    rdReg(8'h02, 1'b1, b0, b1);
    check(b0, 8'h5a);
    check(b1, 8'h3c);
    bus_u.busStart();
    sendChk(8'h4b, 1'b1);
    bus_u.recvByte(1'b0, b0);
    bus_u.busStop();
    check(b0, 8'h3c);
    $display("write test done");
  endtask : t_write

  task automatic t_alert();
    wrReg(8'h02, 8'ha5, 8'h3c);
    tick(10);
    check({7'h0, alertOe}, 8'h00);
    drv0[0] = 1'b0;
    tick(10);
    check({7'h0, alertOe}, 8'h01);
    drv0[0] = 1'b1;
    tick(10);
    check({7'h0, alertOe}, 8'h00);
    drv0[1] = 1'b0;
    drv1[2] = 1'b0;
    tick(10);
    rdReg(8'h00, 1'b0, b0, b1);
    check(b0, 8'had);
    check({7'h0, alertOe}, 8'h01);
    rdReg(8'h01, 1'b0, b0, b1);
    check(b0, 8'hfb);
    tick(4);
    check({7'h0, alertOe}, 8'h00);
    drv1[2] = 1'b1;
    tick(10);
    check({7'h0, alertOe}, 8'h01);
    $display("alert test done");
  endtask : t_alert

  // every strap setting, then foreign traffic with an alert pending
  task automatic t_addr();
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      tick(4);
      bus_u.busStart();
      sendChk({4'h4, strap, 1'b0}, 1'b1);
      bus_u.busStop();
    end
    strap = 3'h5;
    tick(4);
    bus_u.busStart();
    sendChk(8'h48, 1'b0);
    bus_u.busStop();
    bus_u.busStart();
    sendChk(8'h5a, 1'b0);
    bus_u.busStop();
    check({7'h0, alertOe}, 8'h01);
    rdReg(8'h01, 1'b0, b0, b1);
    tick(4);
    check({7'h0, alertOe}, 8'h00);
    $display("address test done");
  endtask : t_addr

  task automatic t_polarity();
    wrReg(8'h04, 8'hff, 8'h00);
    drv0 = 8'h36;
    tick(4);
    rdReg(8'h00, 1'b1, b0, b1);
    check(b0, 8'h59);
    check(b1, 8'hff);
    rdReg(8'h04, 1'b1, b0, b1);
    check(b0, 8'hff);
    check(b1, 8'h00);
    rdReg(8'h06, 1'b1, b0, b1);
    check(b0, 8'h0f);
    check(b1, 8'hff);
    $display("polarity test done");
  endtask : t_polarity

  // reset, then the scenarios in order
  initial begin
    mismatches = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    strap = 3'h5;
    drv0 = 8'hff;
    drv1 = 8'hff;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick(10);
    t_reset();
    t_write();
    t_alert();
    t_addr();
    t_polarity();
    results();
  end

  // a little over three times the expected run length
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule : tb_top
